// >>> rtl/sld_switch_config.sv
// Switch node debug pin and link configuration registers behind APB.
// Assumes link datapath supplies status levels and one-cycle event pulses.
//
// Functional notes
// - Tile config bit 1 lets shared halt raise a core debug request.
// - Tile config bit 0 lets core halted flag drive shared halt.
// - Record origin of latest shared halt: bit 4 pin, bits 1/0 cores.
// - Link status bits 25:24 report source target kind.
// - Link status bits 23:16 report destination link while in use.
// - Switch link direction field 11:8, writable, resets to zero.
// - Switch and processor links hold writable network number 5:4.
// - Read-only bit 2 shows current packet is junk.
// - Bits 1 and 0 show destination and source side in use.
// - Bit 31 of external link config enables or disables the link.
// - Link enable bit also steers pin multiplexing.
// - Bit 30 selects two-wire (0) or five-wire (1) mode.
// - Bit 27 flags receive overflow or illegal token encoding.
// - Bit 26 shows credit granted to remote end.
// - Bit 25 shows this end holds transmit credit.
// - Writing one to bit 24 clears credit and sends greeting token.
// - Writing bit 23 resets receiver to await first symbol.
// - Bits 21:11 set idle clocks between symbols, minus one.
// - Bits 10:0 set idle clocks between tokens, minus one.
// - Static enable forwards all traffic to configured channel end.
// - Static bit 8 picks processor, bits 4:0 pick channel end.
// - Static registers map to links C, D, A, B, G, H, E, F.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module sld_switch_config #(
    parameter int NL = sld_pkg::NUM_LINKS
) (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    input  wire logic [1:0]           core_halted_flag,
    output logic [1:0]                core_debug_req,
    input  wire logic                 halt_pin_in_n,
    output logic                      halt_pin_out_n,
    output logic                      halt_pin_oe,
    input  wire logic [NL-1:0]        switch_link_src_used,
    input  wire logic [NL-1:0]        switch_link_dst_used,
    input  wire logic [NL-1:0]        switch_link_junk,
    input  wire logic [NL*8-1:0]      switch_link_dest_num,
    input  wire logic [NL*2-1:0]      switch_link_src_kind,
    input  wire logic [NL-1:0]        processor_link_src_used,
    input  wire logic [NL-1:0]        processor_link_dst_used,
    input  wire logic [NL-1:0]        processor_link_junk,
    input  wire logic [NL*8-1:0]      processor_link_dest_num,
    input  wire logic [NL*2-1:0]      processor_link_src_kind,
    output logic [NL*4-1:0]           switch_link_direction,
    output logic [NL*2-1:0]           switch_link_network,
    output logic [NL*2-1:0]           processor_link_network,
    input  wire logic [NL-1:0]        xlink_rx_error,
    input  wire logic [NL-1:0]        xlink_credit_granted,
    input  wire logic [NL-1:0]        xlink_credit_received,
    output logic [NL-1:0]             xlink_enable,
    output logic [NL-1:0]             xlink_pin_mux_link,
    output logic [NL-1:0]             xlink_five_wire,
    output logic [NL-1:0]             xlink_send_greeting,
    output logic [NL-1:0]             xlink_rx_reset,
    output logic [NL*11-1:0]          xlink_symbol_gap,
    output logic [NL*11-1:0]          xlink_token_gap,
    output logic [NL-1:0]             static_enable,
    output logic [NL-1:0]             static_proc,
    output logic [NL*5-1:0]           static_chan
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    typedef enum logic [2:0] {
        SLD_REG_NONE = 3'b001,
        SLD_REG_HIT  = 3'b010,
        SLD_REG_BAD  = 3'b100
    } sld_hit_t;

    // True when idx falls in the eight-register group at base
    function automatic logic sld_in_group(input logic [7:0] idx, input logic [7:0] base);
        logic [7:0] d;
        d = idx - base;
        return (idx >= base) && (d < 8'(NL));
    endfunction : sld_in_group

    localparam int LINK_IDX_W = sld_pkg::LINK_IDX_W;
    logic [7:0]            idx;
    logic [LINK_IDX_W-1:0] li;
    logic                  mapped;
    logic                  wr_acc;
    logic                  setup;
    assign idx    = paddr[sld_pkg::ADDR_LSB +: sld_pkg::IDX_W];
    assign li     = idx[LINK_IDX_W-1:0];
    assign mapped = (idx == sld_pkg::IDX_TILE0_CFG) || (idx == sld_pkg::IDX_TILE1_CFG)
                  || (idx == sld_pkg::IDX_HALT_ORIGIN)
                  || sld_in_group(idx, sld_pkg::IDX_LINK_STAT)
                  || sld_in_group(idx, sld_pkg::IDX_PROCESSOR_LINK_STAT)
                  || sld_in_group(idx, sld_pkg::IDX_XLINK_CFG)
                  || sld_in_group(idx, sld_pkg::IDX_STATIC_CFG);
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && mapped && clk_en;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------
    // Shared halt signal and tile config
    // ----------------------------------------
    logic [1:0] halt_req_en;
    logic [1:0] halt_drv_en;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            halt_req_en <= '0;
            halt_drv_en <= '0;
        end else if (wr_acc && idx == sld_pkg::IDX_TILE0_CFG) begin
            halt_req_en[0] <= pwdata[sld_pkg::CFG_HALT_REQ_BIT];
            halt_drv_en[0] <= pwdata[sld_pkg::CFG_HALT_DRV_BIT];
        end else if (wr_acc && idx == sld_pkg::IDX_TILE1_CFG) begin
            halt_req_en[1] <= pwdata[sld_pkg::CFG_HALT_REQ_BIT];
            halt_drv_en[1] <= pwdata[sld_pkg::CFG_HALT_DRV_BIT];
        end
    end

    logic [1:0] core_drive;
    logic       shared_halt_signal;
    logic       shared_halt_q;
    assign core_drive         = core_halted_flag & halt_drv_en;
    assign halt_pin_oe        = |core_drive;
    assign halt_pin_out_n     = 1'b0;
    assign shared_halt_signal = !halt_pin_in_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_debug_req <= '0;
            shared_halt_q  <= 1'b0;
        end else if (clk_en) begin
            core_debug_req <= {2{shared_halt_signal}} & halt_req_en;
            shared_halt_q  <= shared_halt_signal;
        end
    end

    // ----------------------------------------
    // Halt event origin
    // ----------------------------------------
    logic       halt_rise;
    logic [4:0] halt_origin;
    logic [4:0] next_halt_origin;
    assign halt_rise = shared_halt_signal && !shared_halt_q;
    always_comb begin
        next_halt_origin = '0;
        next_halt_origin[sld_pkg::ORG_CORE0_BIT] = core_drive[0];
        next_halt_origin[sld_pkg::ORG_CORE1_BIT] = core_drive[1];
        next_halt_origin[sld_pkg::ORG_PIN_BIT]   = ~|core_drive;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            halt_origin <= '0;
        end else if (clk_en && halt_rise) begin
            halt_origin <= next_halt_origin;
        end else if (wr_acc && idx == sld_pkg::IDX_HALT_ORIGIN) begin
            halt_origin[sld_pkg::ORG_PIN_BIT]   <= pwdata[sld_pkg::ORG_PIN_BIT];
            halt_origin[sld_pkg::ORG_CORE1_BIT] <= pwdata[sld_pkg::ORG_CORE1_BIT];
            halt_origin[sld_pkg::ORG_CORE0_BIT] <= pwdata[sld_pkg::ORG_CORE0_BIT];
        end
    end

    // ----------------------------------------
    // Link direction and network
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            switch_link_direction <= '0;
            switch_link_network   <= '0;
            processor_link_network   <= '0;
        end else if (wr_acc && sld_in_group(idx, sld_pkg::IDX_LINK_STAT)) begin
            switch_link_direction[li*4 +: 4] <= pwdata[sld_pkg::ST_DIR_LSB +: sld_pkg::DIR_W];
            switch_link_network[li*2 +: 2]   <= pwdata[sld_pkg::ST_NET_LSB +: sld_pkg::NET_W];
        end else if (wr_acc && sld_in_group(idx, sld_pkg::IDX_PROCESSOR_LINK_STAT)) begin
            processor_link_network[li*2 +: 2]   <= pwdata[sld_pkg::ST_NET_LSB +: sld_pkg::NET_W];
        end
    end

    // ----------------------------------------
    // External link configuration
    // ----------------------------------------
    logic          xc_wr;
    logic [NL-1:0] xc_sel;
    logic [NL-1:0] err_flag;
    logic [NL-1:0] granted_flag;
    logic [NL-1:0] credit_flag;
    assign xc_wr              = wr_acc && sld_in_group(idx, sld_pkg::IDX_XLINK_CFG);
    assign xc_sel             = xc_wr ? (NL'(1) << li) : '0;
    assign xlink_pin_mux_link = xlink_enable;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xlink_enable     <= '0;
            xlink_five_wire  <= '0;
            xlink_symbol_gap <= '0;
            xlink_token_gap  <= '0;
        end else if (xc_wr) begin
            xlink_enable[li]             <= pwdata[sld_pkg::XC_EN_BIT];
            xlink_five_wire[li]          <= pwdata[sld_pkg::XC_WIRE_BIT];
            xlink_symbol_gap[li*11 +: 11] <= pwdata[sld_pkg::XC_SYM_LSB +: sld_pkg::GAP_W];
            xlink_token_gap[li*11 +: 11]  <= pwdata[sld_pkg::XC_TOK_LSB +: sld_pkg::GAP_W];
        end
    end

    // Command pulses last one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xlink_send_greeting <= '0;
            xlink_rx_reset      <= '0;
        end else if (clk_en) begin
            xlink_send_greeting <= pwdata[sld_pkg::XC_CREDIT_GREETING_TOKEN_BIT] ? xc_sel : '0;
            xlink_rx_reset      <= pwdata[sld_pkg::XC_RXRST_BIT] ? xc_sel : '0;
        end
    end

    // Status flags; a new event wins over a clear
    logic [NL-1:0] credit_greeting_token_clr;
    logic [NL-1:0] rxrst_clr;
    assign credit_greeting_token_clr = pwdata[sld_pkg::XC_CREDIT_GREETING_TOKEN_BIT] ? xc_sel : '0;
    assign rxrst_clr = pwdata[sld_pkg::XC_RXRST_BIT] ? xc_sel : '0;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_flag     <= '0;
            granted_flag <= '0;
            credit_flag  <= '0;
        end else if (clk_en) begin
            err_flag     <= xlink_rx_error | (err_flag & ~rxrst_clr);
            granted_flag <= xlink_enable & (xlink_credit_granted | (granted_flag & ~credit_greeting_token_clr));
            credit_flag  <= xlink_enable & (xlink_credit_received | (credit_flag & ~credit_greeting_token_clr));
        end
    end

    // ----------------------------------------
    // Static forwarding, slot to link letter
    // ----------------------------------------
    logic [LINK_IDX_W-1:0] st_link;
    assign st_link = sld_pkg::STATIC_LINK_MAP[li*LINK_IDX_W +: LINK_IDX_W];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            static_enable <= '0;
            static_proc   <= '0;
            static_chan   <= '0;
        end else if (wr_acc && sld_in_group(idx, sld_pkg::IDX_STATIC_CFG)) begin
            static_enable[st_link]       <= pwdata[sld_pkg::SC_EN_BIT];
            static_proc[st_link]         <= pwdata[sld_pkg::SC_PROC_BIT];
            static_chan[st_link*5 +: 5]  <= pwdata[sld_pkg::SC_CHAN_LSB +: sld_pkg::CHAN_W];
        end
    end

    // ----------------------------------------
    // Read data, captured in setup phase
    // ----------------------------------------
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = '0;
        if (idx == sld_pkg::IDX_TILE0_CFG) begin
            next_prdata[sld_pkg::CFG_HALT_REQ_BIT] = halt_req_en[0];
            next_prdata[sld_pkg::CFG_HALT_DRV_BIT] = halt_drv_en[0];
        end else if (idx == sld_pkg::IDX_TILE1_CFG) begin
            next_prdata[sld_pkg::CFG_HALT_REQ_BIT] = halt_req_en[1];
            next_prdata[sld_pkg::CFG_HALT_DRV_BIT] = halt_drv_en[1];
        end else if (idx == sld_pkg::IDX_HALT_ORIGIN) begin
            next_prdata[4:0] = halt_origin;
        end else if (sld_in_group(idx, sld_pkg::IDX_LINK_STAT)) begin
            next_prdata[sld_pkg::ST_KIND_LSB +: 2]  = switch_link_src_kind[li*2 +: 2];
            next_prdata[sld_pkg::ST_DEST_LSB +: 8]  = switch_link_dest_num[li*8 +: 8];
            next_prdata[sld_pkg::ST_DIR_LSB +: 4]   = switch_link_direction[li*4 +: 4];
            next_prdata[sld_pkg::ST_NET_LSB +: 2]   = switch_link_network[li*2 +: 2];
            next_prdata[sld_pkg::ST_JUNK_BIT]       = switch_link_junk[li];
            next_prdata[sld_pkg::ST_DST_USE_BIT]    = switch_link_dst_used[li];
            next_prdata[sld_pkg::ST_SRC_USE_BIT]    = switch_link_src_used[li];
        end else if (sld_in_group(idx, sld_pkg::IDX_PROCESSOR_LINK_STAT)) begin
            next_prdata[sld_pkg::ST_KIND_LSB +: 2]  = processor_link_src_kind[li*2 +: 2];
            next_prdata[sld_pkg::ST_DEST_LSB +: 8]  = processor_link_dest_num[li*8 +: 8];
            next_prdata[sld_pkg::ST_NET_LSB +: 2]   = processor_link_network[li*2 +: 2];
            next_prdata[sld_pkg::ST_JUNK_BIT]       = processor_link_junk[li];
            next_prdata[sld_pkg::ST_DST_USE_BIT]    = processor_link_dst_used[li];
            next_prdata[sld_pkg::ST_SRC_USE_BIT]    = processor_link_src_used[li];
        end else if (sld_in_group(idx, sld_pkg::IDX_XLINK_CFG)) begin
            next_prdata[sld_pkg::XC_EN_BIT]         = xlink_enable[li];
            next_prdata[sld_pkg::XC_WIRE_BIT]       = xlink_five_wire[li];
            next_prdata[sld_pkg::XC_ERR_BIT]        = err_flag[li];
            next_prdata[sld_pkg::XC_GRANTED_BIT]    = granted_flag[li];
            next_prdata[sld_pkg::XC_CREDIT_BIT]     = credit_flag[li];
            next_prdata[sld_pkg::XC_SYM_LSB +: 11]  = xlink_symbol_gap[li*11 +: 11];
            next_prdata[sld_pkg::XC_TOK_LSB +: 11]  = xlink_token_gap[li*11 +: 11];
        end else if (sld_in_group(idx, sld_pkg::IDX_STATIC_CFG)) begin
            next_prdata[sld_pkg::SC_EN_BIT]         = static_enable[st_link];
            next_prdata[sld_pkg::SC_PROC_BIT]       = static_proc[st_link];
            next_prdata[sld_pkg::SC_CHAN_LSB +: 5]  = static_chan[st_link*5 +: 5];
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (clk_en && setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_DBG_REQ: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && shared_halt_signal && halt_req_en[0] |=> core_debug_req[0])
        else $error("debug request not raised for tile 0");
    AST_PIN_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
        halt_pin_oe == |(core_halted_flag & halt_drv_en))
        else $error("halt pin drive mismatch");
    AST_ORIGIN: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && halt_rise && !halt_pin_oe |=> halt_origin[sld_pkg::ORG_PIN_BIT])
        else $error("pin origin not recorded");
    AST_DIR_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_acc && sld_in_group(idx, sld_pkg::IDX_LINK_STAT) |=>
        switch_link_direction[$past(li)*4 +: 4] == $past(pwdata[sld_pkg::ST_DIR_LSB +: sld_pkg::DIR_W]))
        else $error("direction write lost");
    AST_ENABLE: assert property (@(posedge mclk) disable iff (!rst_n)
        xc_wr && li == '0 |=> xlink_enable[0] == $past(pwdata[31]))
        else $error("link enable write lost");
    AST_MUX: assert property (@(posedge mclk) disable iff (!rst_n)
        xlink_pin_mux_link == xlink_enable)
        else $error("pin mux not following enable");
    AST_ERR_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && xlink_rx_error[0] |=> err_flag[0])
        else $error("error flag not raised");
    AST_CREDIT_GREETING_TOKEN: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && xc_sel[0] && pwdata[24] && !xlink_credit_received[0] |=>
        xlink_send_greeting[0] && !credit_flag[0] ##1 !xlink_send_greeting[0] || !clk_en)
        else $error("greeting not sent or credit kept");
    AST_CREDIT_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && xlink_enable[0] && xlink_credit_received[0] |=> credit_flag[0])
        else $error("credit not recorded");
    AST_STATIC_MAP: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_acc && idx == sld_pkg::IDX_STATIC_CFG |=> static_enable[2] == $past(pwdata[31]))
        else $error("first static slot not link C");
endmodule : sld_switch_config

// >>> include/sld_pkg.sv
// Package for the switch link debug and configuration block.
// Assumes APB word access; register indices map to byte address index*4.
package sld_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_TILE0_CFG   = 8'h10;
    localparam logic [7:0] IDX_TILE1_CFG   = 8'h11;
    localparam logic [7:0] IDX_HALT_ORIGIN = 8'h1F;
    localparam logic [7:0] IDX_LINK_STAT   = 8'h20;
    localparam logic [7:0] IDX_PROCESSOR_LINK_STAT  = 8'h40;
    localparam logic [7:0] IDX_XLINK_CFG   = 8'h80;
    localparam logic [7:0] IDX_STATIC_CFG  = 8'hA0;
    localparam int         NUM_LINKS       = 8;
    localparam int         LINK_IDX_W      = 3;
    localparam int         ADDR_LSB        = 2;
    localparam int         IDX_W           = 8;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CFG_HALT_REQ_BIT  = 1;
    localparam int CFG_HALT_DRV_BIT  = 0;
    localparam int ORG_PIN_BIT       = 4;
    localparam int ORG_CORE1_BIT     = 1;
    localparam int ORG_CORE0_BIT     = 0;
    localparam int ST_KIND_LSB       = 24;
    localparam int ST_DEST_LSB       = 16;
    localparam int ST_DIR_LSB        = 8;
    localparam int ST_NET_LSB        = 4;
    localparam int ST_JUNK_BIT       = 2;
    localparam int ST_DST_USE_BIT    = 1;
    localparam int ST_SRC_USE_BIT    = 0;
    localparam int XC_EN_BIT         = 31;
    localparam int XC_WIRE_BIT       = 30;
    localparam int XC_ERR_BIT        = 27;
    localparam int XC_GRANTED_BIT    = 26;
    localparam int XC_CREDIT_BIT     = 25;
    localparam int XC_CREDIT_GREETING_TOKEN_BIT      = 24;
    localparam int XC_RXRST_BIT      = 23;
    localparam int XC_SYM_LSB        = 11;
    localparam int XC_TOK_LSB        = 0;
    localparam int SC_EN_BIT         = 31;
    localparam int SC_PROC_BIT       = 8;
    localparam int SC_CHAN_LSB       = 0;
    localparam int DIR_W             = 4;
    localparam int NET_W             = 2;
    localparam int GAP_W             = 11;
    localparam int CHAN_W            = 5;
    localparam int DEST_W            = 8;
    localparam int KIND_W            = 2;
    // Static register slot to link letter (A=0 .. H=7): C D A B G H E F
    localparam logic [23:0] STATIC_LINK_MAP = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
endpackage : sld_pkg

// >>> bench/sld_link_partner.sv
// Model of the remote link end and the shared halt pin.
// Assumes one-cycle greeting pulses from the configuration block.
`timescale 1ns/1ps
module sld_link_partner (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] greet,
    input  wire logic [2:0] dly,
    input  wire logic       oe,
    input  wire logic       out_n,
    input  wire logic       ext_halt,
    output logic [7:0]      credit,
    output logic            pin_n
);
    logic [7:0] pend [8];
    // Pull-up; either party pulls low
    assign pin_n = (oe ? out_n : 1'b1) & ~ext_halt;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pend   <= '{default: '0};
            credit <= '0;
        end else begin
            pend[0] <= greet;
            for (int k = 1; k < 8; k++) pend[k] <= pend[k-1];
            credit <= pend[dly];
        end
    end
endmodule : sld_link_partner

// >>> bench/sld_switch_config_tb_top.sv
// Bench for the switch link debug and configuration block.
// Assumes a zero-wait APB slave and the link partner model.
`timescale 1ns/1ps
module sld_switch_config_tb_top;
    logic        mclk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, serr, ext_halt;
    logic        pin_in_n, pin_out_n, pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, s_dir;
    logic [1:0]  halted, dbg_req;
    logic [7:0]  s_src, s_dst, s_junk, p_src, p_dst, p_junk, x_err, x_gr, x_cr, x_en, x_mux, x_five, x_gre, x_rxr;
    logic [7:0]  st_en, st_proc;
    logic [63:0] s_dest, p_dest;
    logic [15:0] s_kind, p_kind, s_net, p_net;
    logic [87:0] x_sym, x_tok;
    logic [39:0] st_chan;
    logic [2:0]  dly;
    int          n_errors, comparisons, n_rxr;
    int          map [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    sld_switch_config i_dut (.mclk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .core_halted_flag(halted), .core_debug_req(dbg_req), .halt_pin_in_n(pin_in_n),
        .halt_pin_out_n(pin_out_n), .halt_pin_oe(pin_oe), .switch_link_src_used(s_src), .switch_link_dst_used(s_dst),
        .switch_link_junk(s_junk), .switch_link_dest_num(s_dest), .switch_link_src_kind(s_kind), .processor_link_src_used(p_src),
        .processor_link_dst_used(p_dst), .processor_link_junk(p_junk), .processor_link_dest_num(p_dest), .processor_link_src_kind(p_kind),
        .switch_link_direction(s_dir), .switch_link_network(s_net), .processor_link_network(p_net), .xlink_rx_error(x_err),
        .xlink_credit_granted(x_gr), .xlink_credit_received(x_cr), .xlink_enable(x_en),
        .xlink_pin_mux_link(x_mux), .xlink_five_wire(x_five), .xlink_send_greeting(x_gre),
        .xlink_rx_reset(x_rxr), .xlink_symbol_gap(x_sym), .xlink_token_gap(x_tok), .static_enable(st_en),
        .static_proc(st_proc), .static_chan(st_chan));
    sld_link_partner i_far (.mclk, .reset_n, .greet(x_gre), .dly, .oe(pin_oe), .out_n(pin_out_n),
        .ext_halt, .credit(x_cr), .pin_n(pin_in_n));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        int t;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, 2'b00, idx, 2'b00, d};
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) n_errors++;
        rdat = prdata;
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        xfer(idx, 1'b0, 32'h0);
        chk("rdata", e, rdat);
    endtask : rdchk
    task automatic stop_test;
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) if (x_rxr[0] === 1'b1) n_rxr++;
    initial begin
        #100us;
        n_errors++;
        stop_test();
    end
    initial begin
        {reset_n, psel, penable, pwrite, ext_halt, halted, x_err, x_gr, paddr, pwdata, dly} = '0;
        {clk_en, s_src, s_dst, s_junk, p_src, p_dst, p_junk} = {1'b1, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
        {s_dest, p_dest, s_kind, p_kind} = {64'h5A, 64'h3C, 16'h2, 16'h1};
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdchk(8'h20, 32'h025A0005);
        rdchk(8'h40, 32'h013C0002);
        rdchk(8'h23, 32'h0);
        xfer(8'h23, 1'b1, 32'hFFFFFFFF);
        rdchk(8'h23, 32'h00000F30);
        chk("dir", 4'hF, s_dir[15:12]);
        xfer(8'h41, 1'b1, 32'hFFFFFFFF);
        rdchk(8'h41, 32'h30);
        chk("net", 4'hF, {s_net[7:6], p_net[3:2]});
        xfer(8'h28, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, serr});
        chk("unmapped", 32'h0, rdat);
        xfer(8'h80, 1'b1, 32'hC0091C56);
        @(posedge mclk);
        chk("xcfg", {3'h7, 11'h123, 11'h456}, {x_en[0], x_mux[0], x_five[0], x_sym[10:0], x_tok[10:0]});
        xfer(8'h80, 1'b1, 32'hC1091C56);
        repeat (6) @(posedge mclk);
        rdchk(8'h80, 32'hC2091C56);
        dly <= 3'h7;
        xfer(8'h80, 1'b1, 32'hC1091C56);
        rdchk(8'h80, 32'hC0091C56);
        repeat (12) @(posedge mclk);
        rdchk(8'h80, 32'hC2091C56);
        {x_gr, x_err} <= 16'h0101;
        @(posedge mclk);
        {x_gr, x_err} <= 16'h0;
        rdchk(8'h80, 32'hCE091C56);
        xfer(8'h80, 1'b1, 32'hC0891C56);
        rdchk(8'h80, 32'hC6091C56);
        chk("rxreset", 1, n_rxr);
        xfer(8'h80, 1'b1, 32'h0);
        rdchk(8'h80, 32'h0);
        chk("enable", 2'b00, {x_en[0], x_mux[0]});
        xfer(8'h10, 1'b1, 32'h3);
        xfer(8'h11, 1'b1, 32'h2);
        halted <= 2'b10;
        repeat (4) @(posedge mclk);
        chk("halt", 3'b000, {pin_oe, dbg_req});
        halted <= 2'b11;
        repeat (4) @(posedge mclk);
        chk("halt", 3'b111, {pin_oe, dbg_req});
        rdchk(8'h1F, 32'h1);
        halted <= 2'b00;
        xfer(8'h1F, 1'b1, 32'h0);
        ext_halt <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("dbgreq", 2'b11, dbg_req);
        rdchk(8'h1F, 32'h10);
        ext_halt <= 1'b0;
        clk_en <= 1'b0;
        xfer(8'hA1, 1'b1, 32'hFFFFFFFF);
        clk_en <= 1'b1;
        @(posedge mclk);
        chk("frozen", 1'b0, st_en[3]);
        for (int s = 0; s < 8; s++) begin
            xfer(8'hA0 + 8'(s), 1'b1, 32'h80000100 | s);
            @(posedge mclk);
            chk("static", {2'b11, 5'(s)}, {st_en[map[s]], st_proc[map[s]], st_chan[map[s]*5 +: 5]});
        end
        rdchk(8'hA7, 32'h80000107);
        stop_test();
    end
endmodule : sld_switch_config_tb_top
